// [step_seq_pkg.sv]
// Purpose: shared constants of the step/direction microstep sequencer
// Assumes: 32-bit APB data, one word per register
// Notes: offsets are byte addresses
`default_nettype none
package step_seq_pkg;
    // =====================================================
    // register offsets
    localparam logic [7:0] ADDR_CHOPPER = 8'h00;
    localparam logic [7:0] ADDR_GLOBAL = 8'h04;
    localparam logic [7:0] ADDR_CURRENT = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_COIL = 8'h10;
    localparam logic [7:0] ADDR_TABLE = 8'h14;
    // =====================================================
    // field positions
    localparam int CH_DEDGE = 0;
    localparam int CH_INTPOL = 1;
    localparam int CH_MRES_LSB = 2;
    localparam int MRES_W = 4;
    localparam int GC_FAST_STST = 0;
    localparam int GC_EXT_STEP = 1;
    localparam int CUR_HOLD_LSB = 0;
    localparam int CUR_RUN_LSB = 8;
    localparam int CUR_W = 5;
    localparam int ST_STST = 16;
    localparam int TBL_ADDR_LSB = 16;
    // =====================================================
    // reset values
    localparam logic [31:0] CHOPPER_RST = 32'h0000_0000;
    localparam logic [31:0] GLOBAL_RST = 32'h0000_0002;
    localparam logic [31:0] CURRENT_RST = 32'h0000_1008;
    // =====================================================
    // sequencer geometry and timing
    localparam int MSCNT_W = 10;
    localparam int TABLE_ENTRIES = 1024;
    localparam int QUARTER_W = 8;
    localparam int AMP_W = 8;
    localparam int COIL_W = 9;
    localparam int REMAIN_W = 9;
    localparam logic [MRES_W-1:0] MRES_FULL = 4'h8;
    localparam logic [MSCNT_W-1:0] FULLSTEP_FIRST = 10'h080;
    localparam int STST_SLOW_CLKS = 2**20;
    localparam int STST_FAST_CLKS = 2**18;
    localparam int STST_CNT_W = 21;
    localparam int TICK_W = 20;
endpackage
`default_nettype wire

// [step_edge_sync.sv]
// Purpose: synchronise step and direction, pick the active step edges
// Assumes: pins may be asynchronous to pclk
// Notes: two flip-flops per pin, edge found after the second
`timescale 1ns/100ps
`default_nettype none
module step_edge_sync (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pins
    input wire logic step_pin,
    input wire logic dir_pin,
    // control
    input wire logic dedge,
    // result
    output logic active_edge,
    output logic dir_sync
);
    logic step_meta, step_s, step_prev;
    logic dir_meta, dir_s;
    wire rise = step_s & ~step_prev;
    wire fall = ~step_s & step_prev;
    wire next_edge = rise | (dedge & fall);

    // =====================================================
    // synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_meta <= 1'b0;
            step_s <= 1'b0;
            dir_meta <= 1'b0;
            dir_s <= 1'b0;
        end else begin
            step_meta <= step_pin;
            step_s <= step_meta;
            dir_meta <= dir_pin;
            dir_s <= dir_meta;
        end
    end

    // =====================================================
    // edge pick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_prev <= 1'b0;
            active_edge <= 1'b0;
            dir_sync <= 1'b0;
        end else begin
            step_prev <= step_s;
            active_edge <= next_edge;
            dir_sync <= dir_s;
        end
    end

    a_rise_only: assert property (@(posedge pclk) disable iff (!presetn)
        (!dedge && fall) |=> !active_edge)
        else $error("falling step edge counted in single-edge mode");
endmodule // step_edge_sync
`default_nettype wire

// [sine_table.sv]
// Purpose: quarter-wave sine table, two registered read ports
// Assumes: software may overwrite entries
// Notes: power-up contents are a parabolic sine approximation
`timescale 1ns/100ps
`default_nettype none
module sine_table #(
    parameter int DEPTH = 256,
    parameter int WIDTH = 8
) (
    // clock
    input wire logic pclk,
    // write port
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // read ports
    input wire logic [$clog2(DEPTH)-1:0] rd_addr_a,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr_b,
    output logic [WIDTH-1:0] rd_data_a,
    output logic [WIDTH-1:0] rd_data_b
);
    logic [WIDTH-1:0] mem [DEPTH];

    if (DEPTH < 2 || WIDTH < 1) begin : g_bad
        $error("table size out of range");
    end

    // half-period parabola, peak just below full scale
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = WIDTH'((((2**WIDTH) - 1) * i * (2 * DEPTH - i)) / (DEPTH * DEPTH));
        end
    end

    // plain always: the power-up loop writes the array as well
    always @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_a <= mem[rd_addr_a];
        rd_data_b <= mem[rd_addr_b];
    end
endmodule // sine_table
`default_nettype wire

// [step_dir_microstep_sequencer.sv]
// Purpose: step/direction driven microstep sequencer with interpolator
// Assumes: APB slave, zero wait states, 40 MHz pclk
// Notes: coil outputs lag the counter by two cycles
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module step_dir_microstep_sequencer #(
    parameter int STST_SLOW_CLKS = step_seq_pkg::STST_SLOW_CLKS,
    parameter int STST_FAST_CLKS = step_seq_pkg::STST_FAST_CLKS
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // step interface
    input wire logic step_in,
    input wire logic dir_in,
    // motor side
    output logic signed [step_seq_pkg::COIL_W-1:0] coil_a,
    output logic signed [step_seq_pkg::COIL_W-1:0] coil_b,
    output logic [step_seq_pkg::CUR_W-1:0] current_scale,
    output logic standstill,
    output logic motion_ctrl_en
);
    localparam int MW = step_seq_pkg::MSCNT_W;
    localparam int QW = step_seq_pkg::QUARTER_W;
    localparam int TW = step_seq_pkg::TICK_W;
    localparam int SW = step_seq_pkg::STST_CNT_W;
    localparam int FULL_STEP = step_seq_pkg::TABLE_ENTRIES / 4;

    // limited by the counter width
    if (STST_FAST_CLKS < 2 || STST_FAST_CLKS > STST_SLOW_CLKS || STST_SLOW_CLKS >= 2**SW) begin : g_bad
        $error("standstill counts out of range");
    end

    // counter must span the table exactly
    if (2**MW != step_seq_pkg::TABLE_ENTRIES || MW != QW + 2) begin : g_bad_geom
        $error("table geometry does not match the counter");
    end

    // =====================================================
    // registers
    logic [31:0] chopper_config, global_config, current_config;
    logic [MW-1:0] mscnt;
    logic [step_seq_pkg::MRES_W-1:0] prev_mres;
    logic [SW-1:0] period_cnt;
    logic [TW-1:0] interval, tick_cnt;
    logic [step_seq_pkg::REMAIN_W-1:0] remaining;
    logic step_dir;
    logic [1:0] quad_a, quad_b;

    wire dedge = chopper_config[step_seq_pkg::CH_DEDGE];
    wire intpol = chopper_config[step_seq_pkg::CH_INTPOL];
    wire [step_seq_pkg::MRES_W-1:0] mres_raw =
        chopper_config[step_seq_pkg::CH_MRES_LSB +: step_seq_pkg::MRES_W];
    wire fast_stst = global_config[step_seq_pkg::GC_FAST_STST];
    wire ext_step = global_config[step_seq_pkg::GC_EXT_STEP];
    wire [step_seq_pkg::CUR_W-1:0] hold_current_scale =
        current_config[step_seq_pkg::CUR_HOLD_LSB +: step_seq_pkg::CUR_W];
    wire [step_seq_pkg::CUR_W-1:0] run_current_scale =
        current_config[step_seq_pkg::CUR_RUN_LSB +: step_seq_pkg::CUR_W];

    // =====================================================
    // apb decode
    wire setup = psel & ~penable;
    wire wr_take = psel & penable & pready & pwrite;
    wire hit_chop = paddr == step_seq_pkg::ADDR_CHOPPER;
    wire hit_glob = paddr == step_seq_pkg::ADDR_GLOBAL;
    wire hit_cur = paddr == step_seq_pkg::ADDR_CURRENT;
    wire hit_stat = paddr == step_seq_pkg::ADDR_STATUS;
    wire hit_coil = paddr == step_seq_pkg::ADDR_COIL;
    wire hit_tbl = paddr == step_seq_pkg::ADDR_TABLE;
    wire mapped = hit_chop | hit_glob | hit_cur | hit_stat | hit_coil | hit_tbl;
    wire [31:0] status_word = 32'(mscnt) | (32'(standstill) << step_seq_pkg::ST_STST);
    wire [31:0] coil_word = {7'h00, coil_b, 7'h00, coil_a};
    wire [31:0] read_word = hit_chop ? chopper_config :
                            hit_glob ? global_config :
                            hit_cur ? current_config :
                            hit_stat ? status_word :
                            hit_coil ? coil_word : 32'h0000_0000;
    wire tbl_wr = wr_take & hit_tbl;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            prdata <= (setup & ~pwrite) ? read_word : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chopper_config <= step_seq_pkg::CHOPPER_RST;
            global_config <= step_seq_pkg::GLOBAL_RST;
            current_config <= step_seq_pkg::CURRENT_RST;
        end else if (wr_take) begin
            if (hit_chop) chopper_config <= pwdata;
            if (hit_glob) global_config <= pwdata;
            if (hit_cur) current_config <= pwdata;
        end
    end

    // =====================================================
    // step input
    logic edge_raw, dir_s;
    step_edge_sync u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .step_pin(step_in),
        .dir_pin(dir_in),
        .dedge(dedge),
        .active_edge(edge_raw),
        .dir_sync(dir_s)
    );
    // internal ramp is off only in external step mode
    wire act = edge_raw & ext_step;

    // =====================================================
    // step width and snapping
    wire [step_seq_pkg::MRES_W-1:0] mres =
        (mres_raw > step_seq_pkg::MRES_FULL) ? step_seq_pkg::MRES_FULL : mres_raw;
    wire [MW-1:0] step_width = MW'(1) << mres;
    wire [MW-1:0] snapped = (mres == '0) ? mscnt :
                            ((mscnt & ~(step_width - MW'(1))) | (step_width >> 1));
    wire do_snap = ~intpol & (mres != prev_mres);

    // =====================================================
    // interpolator timing
    wire [SW-1:0] period_sh = period_cnt >> mres;
    wire [TW-1:0] next_interval = period_sh[SW-1] ? {TW{1'b1}} : period_sh[TW-1:0];
    wire micro_tick = intpol & (remaining != '0) & (tick_cnt >= interval);
    wire [MW-1:0] coarse_delta = dir_s ? (MW'(0) - step_width) : step_width;
    wire [MW-1:0] fine_delta = dir_s ? {MW{1'b1}} : MW'(1);
    wire [MW-1:0] tick_delta = step_dir ? {MW{1'b1}} : MW'(1);
    wire [SW-1:0] stst_limit = fast_stst ? SW'(STST_FAST_CLKS) : SW'(STST_SLOW_CLKS);

    logic [MW-1:0] next_mscnt;
    always_comb begin
        next_mscnt = mscnt;
        if (act && !intpol) begin
            next_mscnt = mscnt + coarse_delta;
        end else if (act) begin
            next_mscnt = mscnt + fine_delta;
        end else if (micro_tick) begin
            next_mscnt = mscnt + tick_delta;
        end else if (do_snap) begin
            next_mscnt = snapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mscnt <= '0;
            prev_mres <= '0;
        end else begin
            mscnt <= next_mscnt;
            // a step edge wins, the snap follows one cycle later
            if (!act) prev_mres <= mres;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_cnt <= '0;
            interval <= {TW{1'b1}};
            tick_cnt <= '0;
            remaining <= '0;
            step_dir <= 1'b0;
        end else if (act) begin
            period_cnt <= '0;
            interval <= next_interval;
            tick_cnt <= '0;
            remaining <= intpol ? step_seq_pkg::REMAIN_W'(step_width - MW'(1)) : '0;
            step_dir <= dir_s;
        end else begin
            if (period_cnt != {SW{1'b1}}) period_cnt <= period_cnt + SW'(1);
            tick_cnt <= micro_tick ? '0 : tick_cnt + TW'(1);
            if (micro_tick) remaining <= remaining - step_seq_pkg::REMAIN_W'(1);
            if (!intpol) remaining <= '0;
        end
    end

    // =====================================================
    // standstill and current
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            standstill <= 1'b0;
            current_scale <= '0;
            motion_ctrl_en <= 1'b0;
        end else begin
            if (act) begin
                standstill <= 1'b0;
            end else if (period_cnt >= stst_limit - SW'(1)) begin
                standstill <= 1'b1;
            end
            current_scale <= standstill ? hold_current_scale : run_current_scale;
            motion_ctrl_en <= ~ext_step;
        end
    end

    // =====================================================
    // sine lookup, sine on coil a and cosine on coil b
    wire [MW-1:0] pos_b = mscnt + MW'(step_seq_pkg::TABLE_ENTRIES / 4);
    // mirrored quadrants read 256 - index so full steps give equal coil magnitudes; the peak reuses the last entry
    wire [QW-1:0] low_a = mscnt[QW-1:0];
    wire [QW-1:0] low_b = pos_b[QW-1:0];
    wire [QW-1:0] mir_a = (low_a == '0) ? {QW{1'b1}} : (QW'(0) - low_a);
    wire [QW-1:0] mir_b = (low_b == '0) ? {QW{1'b1}} : (QW'(0) - low_b);
    wire [QW-1:0] idx_a = mscnt[QW] ? mir_a : low_a;
    wire [QW-1:0] idx_b = pos_b[QW] ? mir_b : low_b;
    logic [step_seq_pkg::AMP_W-1:0] mag_a, mag_b;
    sine_table #(
        .DEPTH(step_seq_pkg::TABLE_ENTRIES / 4),
        .WIDTH(step_seq_pkg::AMP_W)
    ) u_table (
        .pclk(pclk),
        .wr_en(tbl_wr),
        .wr_addr(pwdata[step_seq_pkg::TBL_ADDR_LSB +: QW]),
        .wr_data(pwdata[step_seq_pkg::AMP_W-1:0]),
        .rd_addr_a(idx_a),
        .rd_addr_b(idx_b),
        .rd_data_a(mag_a),
        .rd_data_b(mag_b)
    );
    wire [step_seq_pkg::COIL_W-1:0] amp_a = {1'b0, mag_a};
    wire [step_seq_pkg::COIL_W-1:0] amp_b = {1'b0, mag_b};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quad_a <= 2'h0;
            quad_b <= 2'h0;
            coil_a <= '0;
            coil_b <= '0;
        end else begin
            quad_a <= mscnt[MW-1:MW-2];
            quad_b <= pos_b[MW-1:MW-2];
            coil_a <= quad_a[1] ? -amp_a : amp_a;
            coil_b <= quad_b[1] ? -amp_b : amp_b;
        end
    end

    // =====================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_coarse_edge;
        act && !intpol && !do_snap;
    endsequence
    sequence s_settled;
        !intpol && !act && !do_snap && !micro_tick;
    endsequence
    sequence s_full_rest;
        s_settled and mres == step_seq_pkg::MRES_FULL;
    endsequence

    a_step_forward: assert property (s_coarse_edge and !dir_s |=>
        mscnt == $past(mscnt) + $past(step_width))
        else $error("forward step width wrong");
    a_step_backward: assert property (s_coarse_edge and dir_s |=>
        mscnt == $past(mscnt) - $past(step_width))
        else $error("backward step width wrong");
    a_full_positions: assert property (s_settled and mres == step_seq_pkg::MRES_FULL
        |-> mscnt[QW-1:0] == step_seq_pkg::FULLSTEP_FIRST[QW-1:0])
        else $error("full step off its table position");
    a_grid_positions: assert property (s_settled and mres != '0
        |-> (mscnt & (step_width - MW'(1))) == (step_width >> 1))
        else $error("position off the resolution grid");
    a_interp_first: assert property (act && intpol |=>
        mscnt == $past(mscnt) + (($past(dir_s)) ? {MW{1'b1}} : MW'(1))
        ##0 remaining == step_seq_pkg::REMAIN_W'($past(step_width) - MW'(1)))
        else $error("interpolated step did not start");
    a_interp_off: assert property (!intpol |=> remaining == '0)
        else $error("interpolator active while disabled");
    a_stst_clear: assert property (standstill && act |=> !standstill)
        else $error("standstill not cleared by step");
    a_stst_set: assert property (!act && !standstill && period_cnt == stst_limit - SW'(1)
        |=> standstill)
        else $error("standstill not set at limit");
    a_stst_early: assert property (!standstill && period_cnt < stst_limit - SW'(1) |=> !standstill)
        else $error("standstill set too early");
    a_hold_current: assert property (standstill |=> current_scale == $past(hold_current_scale))
        else $error("hold current not applied");
    a_run_current: assert property (!standstill |=> current_scale == $past(run_current_scale))
        else $error("run current not applied");
    a_ramp_off: assert property (ext_step |=> !motion_ctrl_en ##0 $past(act) == $past(edge_raw))
        else $error("internal controller not switched off");
    a_ext_ignored: assert property (edge_raw && !ext_step && !intpol && !do_snap
        |=> mscnt == $past(mscnt))
        else $error("step taken with external stepping off");
    a_full_width: assert property (s_coarse_edge and mres == step_seq_pkg::MRES_FULL |=>
        mscnt == $past(mscnt) + ($past(dir_s) ? MW'(0 - FULL_STEP) : MW'(FULL_STEP)))
        else $error("full step width wrong");
    a_full_balance: assert property (s_full_rest ##1 s_full_rest ##1 s_full_rest |=>
        coil_a == coil_b || coil_a == -coil_b)
        else $error("full step coils not balanced");
    a_tick_step: assert property (micro_tick && !act |=>
        mscnt == $past(mscnt) + ($past(step_dir) ? {MW{1'b1}} : MW'(1)))
        else $error("interpolated microstep wrong");
    a_stst_quick: assert property (fast_stst && !act && !standstill
        && period_cnt == SW'(STST_FAST_CLKS) - SW'(1) |=> standstill)
        else $error("quick standstill not set at limit");
endmodule // step_dir_microstep_sequencer
`default_nettype wire

// [step_source.sv]
// Purpose: step and direction source model for the sequencer bench
// Assumes: called from the bench right after a rising pclk edge
// Notes: both step levels held at least 2 clocks
`timescale 1ns/100ps
`default_nettype none
module step_source (
    // clock
    input wire logic pclk,
    // pins
    output logic step_pin,
    output logic dir_pin
);
    // ==========================================
    // pulse train
    initial begin
        step_pin = 1'b0;
        dir_pin = 1'b0;
    end
    // equal halves keep double-edge stepping even; dir settles two clocks ahead; halves of 2+ keep the rate legal
    task automatic pulses(input logic d, input int n, input int half);
        dir_pin <= d;
        repeat (2) @(posedge pclk);
        repeat (n) begin
            step_pin <= 1'b1;
            repeat (half) @(posedge pclk);
            step_pin <= 1'b0;
            repeat (half) @(posedge pclk);
        end
    endtask
endmodule // step_source
`default_nettype wire

// [test_step_dir_microstep_sequencer.sv]
// Purpose: self-checking bench of the microstep sequencer
// Assumes: short standstill limits 1024 and 64
// Notes: counter read back through the status register
`timescale 1ns/100ps
`default_nettype none
module test_step_dir_microstep_sequencer;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic step_in, dir_in, standstill, motion_ctrl_en;
    logic signed [step_seq_pkg::COIL_W-1:0] coil_a, coil_b;
    logic [step_seq_pkg::CUR_W-1:0] current_scale;
    int error_cnt = 0;
    int num_checks = 0;
    int i;
    // ==========================================
    // design and partner
    step_dir_microstep_sequencer #(.STST_SLOW_CLKS(1024), .STST_FAST_CLKS(64)) i_dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .step_in(step_in), .dir_in(dir_in), .coil_a(coil_a), .coil_b(coil_b),
        .current_scale(current_scale), .standstill(standstill), .motion_ctrl_en(motion_ctrl_en));
    step_source i_src (.pclk(pclk), .step_pin(step_in), .dir_pin(dir_in));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // ==========================================
    // shared tasks
    task test_done;
        $display("checks %0d, errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        logic ok;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        ok = (pready === 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge, so a following call never drives psel twice in one time step
        @(posedge pclk);
        if (!ok) begin
            error_cnt++;
            test_done();
        end
    endtask
    task cfg(input logic [3:0] mres, input logic ip, input logic de);
        apb(1'b1, step_seq_pkg::ADDR_CHOPPER, {26'h0, mres, ip, de});
    endtask
    task cnt(input logic [9:0] exp);
        repeat (8) @(posedge pclk);
        apb(1'b0, step_seq_pkg::ADDR_STATUS, 32'h0);
        chk({22'h0, rd[9:0]}, {22'h0, exp});
    endtask
    task move(input logic d, input int n, input logic [9:0] exp);
        i_src.pulses(d, n, 2);
        cnt(exp);
    endtask
    // ==========================================
    // scenarios
    task t_reset;
        apb(1'b0, step_seq_pkg::ADDR_CHOPPER, 32'h0);
        chk(rd, 32'h0000_0000);
        apb(1'b0, step_seq_pkg::ADDR_GLOBAL, 32'h0);
        chk(rd, 32'h0000_0002);
        apb(1'b0, step_seq_pkg::ADDR_CURRENT, 32'h0);
        chk(rd, 32'h0000_1008);
        chk(32'(motion_ctrl_en), 32'h0);
    endtask
    task t_steps;
        move(1'b0, 3, 10'h003);
        move(1'b1, 5, 10'h3fe);
    endtask
    task t_res;
        cfg(4'h8, 1'b0, 1'b0);
        cnt(10'h380);
        move(1'b0, 1, 10'h080);
        chk(32'(coil_a), 32'(coil_b));
        chk(32'(coil_a > 0), 32'h1);
        apb(1'b0, step_seq_pkg::ADDR_COIL, 32'h0);
        chk({23'h0, rd[8:0]}, {23'h0, rd[24:16]});
        apb(1'b1, step_seq_pkg::ADDR_TABLE, 32'h0080_0055);
        repeat (4) @(posedge pclk);
        chk(32'(coil_a), 32'h55);
        chk(32'(coil_b), 32'h55);
        cfg(4'h7, 1'b0, 1'b0);
        cnt(10'h0c0);
        move(1'b0, 1, 10'h140);
        cfg(4'h6, 1'b0, 1'b0);
        cnt(10'h160);
        move(1'b1, 1, 10'h120);
    endtask
    task t_dedge;
        cfg(4'h0, 1'b0, 1'b1);
        move(1'b0, 1, 10'h122);
        cfg(4'h0, 1'b0, 1'b0);
        move(1'b0, 1, 10'h123);
    endtask
    task t_interp;
        cfg(4'h2, 1'b1, 1'b0);
        repeat (400) @(posedge pclk);
        i_src.pulses(1'b0, 3, 32);
        cnt(10'h12c);
        fork
            i_src.pulses(1'b0, 1, 32);
            begin
                repeat (10) @(posedge pclk);
                apb(1'b0, step_seq_pkg::ADDR_STATUS, 32'h0);
                chk({22'h0, rd[9:0]}, 32'h0000_012d);
            end
        join
        cnt(10'h130);
    endtask
    task stst_wait(input int lim);
        i_src.pulses(1'b0, 1, 2);
        repeat (2) @(posedge pclk);
        chk(32'(standstill), 32'h0);
        chk(32'(current_scale), 32'h10);
        for (i = 0; i < 1200 && standstill !== 1'b1; i++) @(posedge pclk);
        chk(32'(i > lim - 9 && i < lim + 9), 32'h1);
        repeat (2) @(posedge pclk);
        chk(32'(current_scale), 32'h08);
    endtask
    task t_stst;
        cfg(4'h0, 1'b0, 1'b0);
        stst_wait(1024);
        apb(1'b1, step_seq_pkg::ADDR_GLOBAL, 32'h3);
        stst_wait(64);
        cnt(10'h132);
    endtask
    task t_ext;
        apb(1'b1, step_seq_pkg::ADDR_GLOBAL, 32'h0);
        repeat (2) @(posedge pclk);
        chk(32'(motion_ctrl_en), 32'h1);
        move(1'b0, 1, 10'h132);
        apb(1'b0, 8'h20, 32'h0);
        chk(32'(err), 32'h1);
        chk(rd, 32'h0);
    endtask
    // ==========================================
    // main sequence and watchdog
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_steps();
        t_res();
        t_dedge();
        t_interp();
        t_stst();
        t_ext();
        test_done();
    end
    initial begin
        repeat (100000) @(posedge pclk);
        error_cnt++;
        test_done();
    end
endmodule // test_step_dir_microstep_sequencer
`default_nettype wire
